// [core/rcr_pkg.sv]
package rcr_pkg;

  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0] OP_CARRY_CLEAR = 8'hcf;
  localparam logic [7:0] OP_RETURN = 8'haf;
  localparam logic [7:0] OP_ROT_L = 8'h90;
  localparam logic [7:0] OP_ROT_L_IND = 8'h91;
  localparam logic [7:0] OP_ROT_LC = 8'h10;
  localparam logic [7:0] OP_ROT_LC_IND = 8'h11;
  localparam logic [7:0] OP_ROT_R = 8'he0;
  localparam logic [7:0] OP_ROT_R_IND = 8'he1;
  localparam logic [7:0] OP_ROT_RC = 8'hc0;
  localparam logic [7:0] OP_ROT_RC_IND = 8'hc1;

  // ************************************************************
  // cycle counts and sequencing steps
  // ************************************************************
  localparam logic [3:0] CYC_CARRY_CLEAR = 4'h6;
  localparam logic [3:0] CYC_RETURN = 4'he;
  localparam logic [3:0] CYC_ROTATE = 4'h6;
  localparam logic [3:0] CNT_COMMIT = 4'h2;
  localparam logic [3:0] CNT_DONE = 4'h1;
  localparam logic [15:0] SP_POP_STEP = 16'h0002;

  // ************************************************************
  // flag layout and reset values
  // ************************************************************
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  localparam logic [7:0] FLAG_C_MASK = 8'h80;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h0000;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADR_FLAGS = 8'h00;
  localparam logic [7:0] ADR_PC = 8'h04;
  localparam logic [7:0] ADR_SP = 8'h08;
  localparam logic [7:0] ADR_REG_ADDR = 8'h0c;
  localparam logic [7:0] ADR_REG_DATA = 8'h10;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADR_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] ADR_IRQ_ENABLE = 8'h1c;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ILLEGAL = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] RST_IRQ = 2'h0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    K_NONE, K_CARRY_CLEAR, K_RETURN, K_ROT_L, K_ROT_LC, K_ROT_R, K_ROT_RC
  } rcr_kind_t;
  typedef enum logic {ST_IDLE, ST_EXEC} rcr_state_t;
  typedef enum logic [1:0] {WB_IDLE, WB_PREP, WB_ACK} rcr_wb_t;

endpackage : rcr_pkg

// [core/rcr_mem_if.sv]
`timescale 1ns/1ns
interface rcr_mem_if #(parameter int AW = 8, parameter int DW = 8);
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  modport ctrl (output rd_en, rd_addr, wr_en, wr_addr, wr_data, input rd_data);
  modport mem (input rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface : rcr_mem_if

// [core/rcr_regmem.sv]
`timescale 1ns/1ns
module rcr_regmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // storage port
  rcr_mem_if.mem port_if
);

  if (AW < 1 || AW > 12 || DW < 1) begin : g_chk
    $error("rcr_regmem: unsupported width or depth");
  end

  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rd_q;

  // read data registered: one cycle from rd_en to rd_data
  always_ff @(posedge clk) begin
    if (port_if.wr_en) begin
      mem_q[port_if.wr_addr] <= port_if.wr_data;
    end
    if (rst) begin
      rd_q <= '0;
    end else if (port_if.rd_en) begin
      rd_q <= mem_q[port_if.rd_addr];
    end
  end

  assign port_if.rd_data = rd_q;

endmodule : rcr_regmem

// [core/rcr_exec_top.sv]
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
module rcr_exec_top import rcr_pkg::*; #(
  parameter int REG_AW = 8
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // instruction issue from decoder
  input wire logic INSTR_VALID,
  input wire logic [7:0] INSTR_OPCODE,
  input wire logic [7:0] INSTR_OPERAND,
  output logic INSTR_READY,
  output logic INSTR_DONE,
  // architectural state
  output logic [15:0] PC_OUT,
  output logic [15:0] SP_OUT,
  output logic [7:0] FLAGS_OUT,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // interrupt
  output logic IRQ
);

  if (REG_AW < 1 || REG_AW > 8) begin : g_chk
    $error("rcr_exec_top: REG_AW must be 1 to 8");
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic rcr_kind_t op_kind(input logic [7:0] op);
    unique case (op)
      OP_CARRY_CLEAR: op_kind = K_CARRY_CLEAR;
      OP_RETURN: op_kind = K_RETURN;
      OP_ROT_L, OP_ROT_L_IND: op_kind = K_ROT_L;
      OP_ROT_LC, OP_ROT_LC_IND: op_kind = K_ROT_LC;
      OP_ROT_R, OP_ROT_R_IND: op_kind = K_ROT_R;
      OP_ROT_RC, OP_ROT_RC_IND: op_kind = K_ROT_RC;
      default: op_kind = K_NONE;
    endcase
  endfunction : op_kind

  // returns {carry_out, result}
  function automatic logic [8:0] rotate(input rcr_kind_t k, input logic [7:0] v,
                                        input logic c);
    unique case (k)
      K_ROT_L: rotate = {v[7], v[6:0], v[7]};
      K_ROT_LC: rotate = {v[7], v[6:0], c};
      K_ROT_R: rotate = {v[0], v[0], v[7:1]};
      K_ROT_RC: rotate = {v[0], c, v[7:1]};
      default: rotate = {c, v};
    endcase
  endfunction : rotate

  // merges the enabled byte lanes of a write into a 16-bit value
  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
    lane16[7:0] = sel[0] ? wd[7:0] : old[7:0];
    lane16[15:8] = sel[1] ? wd[15:8] : old[15:8];
  endfunction : lane16

  // ************************************************************
  // state
  // ************************************************************
  rcr_state_t st_q, st_d;
  rcr_kind_t kind_q, kind_d;
  rcr_wb_t wb_q, wb_d;
  logic [3:0] cnt_q, cnt_d;
  logic ind_q, ind_d;
  logic [7:0] opnd_q, opnd_d, val_q, val_d, aux_q, aux_d;
  logic [REG_AW-1:0] dst_q, dst_d;
  logic [15:0] pc_q, pc_d, sp_q, sp_d, sp_next;
  logic [7:0] flags_q, flags_d, regaddr_q, regaddr_d;
  logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d, ev, clr;
  logic [31:0] rdat_q, rdat_d;
  logic [8:0] rot;
  logic wb_req, wb_take, wb_wr, instr_rdy, acc, done, rot_kind;
  rcr_kind_t new_kind;

  rcr_mem_if #(.AW(REG_AW), .DW(8)) mem_if ();

  rcr_regmem #(.AW(REG_AW), .DW(8)) u_mem (
    .clk(REF_CLK),
    .rst(RESET),
    .port_if(mem_if.mem)
  );

  assign wb_req = WB_CYC_I & WB_STB_I;
  assign instr_rdy = (st_q == ST_IDLE) && (wb_q == WB_IDLE);
  // an instruction wins over a bus request arriving in the same cycle
  assign acc = INSTR_VALID & instr_rdy;
  assign wb_take = wb_req & instr_rdy & ~INSTR_VALID;
  assign wb_wr = (wb_q == WB_ACK) && wb_req && WB_WE_I;
  assign done = (st_q == ST_EXEC) && (cnt_q == CNT_DONE);
  assign new_kind = op_kind(INSTR_OPCODE);
  assign sp_next = sp_q + 16'h0001;
  assign rot_kind = kind_q inside {K_ROT_L, K_ROT_LC, K_ROT_R, K_ROT_RC};
  assign rot = rotate(kind_q, val_q, flags_q[FLG_C]);

  // ************************************************************
  // execution and architectural state
  // ************************************************************
  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    ind_d = ind_q;
    opnd_d = opnd_q;
    val_d = val_q;
    aux_d = aux_q;
    dst_d = dst_q;
    pc_d = pc_q;
    sp_d = sp_q;
    flags_d = flags_q;
    regaddr_d = regaddr_q;
    ien_d = ien_q;
    clr = '0;
    mem_if.rd_en = 1'b0;
    mem_if.rd_addr = '0;
    mem_if.wr_en = 1'b0;
    mem_if.wr_addr = '0;
    mem_if.wr_data = 8'h00;
    ev = '0;
    ev[IRQ_DONE] = done;
    ev[IRQ_ILLEGAL] = acc && (new_kind == K_NONE);
    unique case (st_q)
      ST_IDLE: begin
        if (acc && new_kind != K_NONE) begin
          st_d = ST_EXEC;
          kind_d = new_kind;
          ind_d = INSTR_OPCODE[0];
          opnd_d = INSTR_OPERAND;
          cnt_d = (new_kind == K_RETURN) ? CYC_RETURN - 4'h1 : CYC_ROTATE - 4'h1;
          if (new_kind == K_CARRY_CLEAR) begin
            cnt_d = CYC_CARRY_CLEAR - 4'h1;
          end
        end
        if (wb_take && !WB_WE_I && WB_ADR_I == ADR_REG_DATA) begin
          mem_if.rd_en = 1'b1;
          mem_if.rd_addr = regaddr_q[REG_AW-1:0];
        end
        if (wb_wr) begin
          unique case (WB_ADR_I)
            ADR_FLAGS: flags_d = WB_SEL_I[0] ? WB_DAT_I[7:0] : flags_q;
            ADR_PC: pc_d = lane16(pc_q, WB_DAT_I, WB_SEL_I);
            ADR_SP: sp_d = lane16(sp_q, WB_DAT_I, WB_SEL_I);
            ADR_REG_ADDR: regaddr_d = WB_SEL_I[0] ? WB_DAT_I[7:0] : regaddr_q;
            ADR_REG_DATA: begin
              mem_if.wr_en = WB_SEL_I[0];
              mem_if.wr_addr = regaddr_q[REG_AW-1:0];
              mem_if.wr_data = WB_DAT_I[7:0];
            end
            ADR_IRQ_CLEAR: clr = WB_SEL_I[0] ? WB_DAT_I[IRQ_W-1:0] : '0;
            ADR_IRQ_ENABLE: ien_d = WB_SEL_I[0] ? WB_DAT_I[IRQ_W-1:0] : ien_q;
            default: ;
          endcase
        end
      end
      ST_EXEC: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == CNT_DONE) begin
          st_d = ST_IDLE;
        end
        if (kind_q == K_RETURN) begin
          if (cnt_q == CYC_RETURN - 4'h1) begin
            mem_if.rd_en = 1'b1;
            mem_if.rd_addr = sp_q[REG_AW-1:0];
          end
          if (cnt_q == CYC_RETURN - 4'h2) begin
            val_d = mem_if.rd_data;
            mem_if.rd_en = 1'b1;
            mem_if.rd_addr = sp_next[REG_AW-1:0];
          end
          if (cnt_q == CYC_RETURN - 4'h3) begin
            aux_d = mem_if.rd_data;
          end
          if (cnt_q == CNT_COMMIT) begin
            // flags are not touched on this path
            pc_d = {val_q, aux_q};
            sp_d = sp_q + SP_POP_STEP;
          end
        end else if (kind_q == K_CARRY_CLEAR) begin
          if (cnt_q == CNT_COMMIT) begin
            flags_d[FLG_C] = 1'b0;
          end
        end else begin
          if (cnt_q == CYC_ROTATE - 4'h1) begin
            mem_if.rd_en = 1'b1;
            mem_if.rd_addr = opnd_q[REG_AW-1:0];
          end
          if (cnt_q == CYC_ROTATE - 4'h2) begin
            val_d = mem_if.rd_data;
            dst_d = ind_q ? mem_if.rd_data[REG_AW-1:0] : opnd_q[REG_AW-1:0];
            mem_if.rd_en = ind_q;
            mem_if.rd_addr = mem_if.rd_data[REG_AW-1:0];
          end
          if (cnt_q == CYC_ROTATE - 4'h3 && ind_q) begin
            val_d = mem_if.rd_data;
          end
          if (cnt_q == CNT_COMMIT) begin
            mem_if.wr_en = 1'b1;
            mem_if.wr_addr = dst_q;
            mem_if.wr_data = rot[7:0];
            flags_d[FLG_C] = rot[8];
            flags_d[FLG_Z] = (rot[7:0] == 8'h00);
            flags_d[FLG_S] = rot[7];
            flags_d[FLG_V] = rot[7] ^ val_q[7];
          end
        end
      end
    endcase
    // a new event wins over a clear in the same cycle
    ist_d = (ist_q & ~clr) | ev;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      st_q <= ST_IDLE;
      kind_q <= K_NONE;
      cnt_q <= 4'h0;
      ind_q <= 1'b0;
      opnd_q <= 8'h00;
      val_q <= 8'h00;
      aux_q <= 8'h00;
      dst_q <= '0;
      pc_q <= RST_PC;
      sp_q <= RST_SP;
      flags_q <= RST_FLAGS;
      regaddr_q <= 8'h00;
      ist_q <= RST_IRQ;
      ien_q <= RST_IRQ;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      ind_q <= ind_d;
      opnd_q <= opnd_d;
      val_q <= val_d;
      aux_q <= aux_d;
      dst_q <= dst_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      flags_q <= flags_d;
      regaddr_q <= regaddr_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
    end
  end

  // ************************************************************
  // wishbone sequencing
  // ************************************************************
  // two-stage answer so that read data always leaves a flop
  always_comb begin
    wb_d = wb_q;
    rdat_d = rdat_q;
    unique case (wb_q)
      WB_IDLE: if (wb_take) begin
        wb_d = WB_PREP;
      end
      WB_PREP: begin
        wb_d = WB_ACK;
        unique case (WB_ADR_I)
          ADR_FLAGS: rdat_d = {24'h000000, flags_q};
          ADR_PC: rdat_d = {16'h0000, pc_q};
          ADR_SP: rdat_d = {16'h0000, sp_q};
          ADR_REG_ADDR: rdat_d = {24'h000000, regaddr_q};
          ADR_REG_DATA: rdat_d = {24'h000000, mem_if.rd_data};
          ADR_IRQ_STATUS: rdat_d = {{(32 - IRQ_W){1'b0}}, ist_q};
          ADR_IRQ_ENABLE: rdat_d = {{(32 - IRQ_W){1'b0}}, ien_q};
          default: rdat_d = 32'h00000000;
        endcase
      end
      WB_ACK: wb_d = WB_IDLE;
      default: wb_d = WB_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      wb_q <= WB_IDLE;
      rdat_q <= 32'h00000000;
    end else begin
      wb_q <= wb_d;
      rdat_q <= rdat_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign INSTR_READY = instr_rdy;
  assign INSTR_DONE = done;
  assign PC_OUT = pc_q;
  assign SP_OUT = sp_q;
  assign FLAGS_OUT = flags_q;
  assign WB_DAT_O = rdat_q;
  assign WB_ACK_O = (wb_q == WB_ACK) && wb_req;
  assign IRQ = |(ist_q & ien_q);

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  AST_CARRY_CLEAR: assert property (
    acc && INSTR_OPCODE == OP_CARRY_CLEAR |-> ##5 (INSTR_DONE && !flags_q[FLG_C] &&
      (flags_q & ~FLAG_C_MASK) == ($past(flags_q, 5) & ~FLAG_C_MASK)))
    else $error("carry clear timing or flags wrong");
  AST_RETURN_SP: assert property (
    acc && INSTR_OPCODE == OP_RETURN |->
      ##13 (INSTR_DONE && sp_q == 16'($past(sp_q, 13) + SP_POP_STEP)))
    else $error("return timing or stack pointer wrong");
  AST_RETURN_BYTES: assert property (
    acc && INSTR_OPCODE == OP_RETURN |->
      ##13 (pc_q == {$past(mem_if.rd_data, 11), $past(mem_if.rd_data, 10)}))
    else $error("return counter byte order wrong");
  AST_RETURN_FLAGS: assert property (
    acc && INSTR_OPCODE == OP_RETURN |-> ##13 (flags_q == $past(flags_q, 13)))
    else $error("return changed flags");
  AST_ROT_TIME: assert property (
    acc && new_kind inside {K_ROT_L, K_ROT_LC, K_ROT_R, K_ROT_RC} |->
      ##1 !INSTR_DONE [*4] ##1 INSTR_DONE)
    else $error("rotate not done in 6 cycles");
  AST_ROT_L: assert property (
    INSTR_DONE && kind_q == K_ROT_L |-> $past(mem_if.wr_en) &&
      $past(mem_if.wr_data) == {val_q[6:0], val_q[7]} && flags_q[FLG_C] == val_q[7])
    else $error("rotate left wrong");
  AST_ROT_LC: assert property (
    INSTR_DONE && kind_q == K_ROT_LC |-> $past(mem_if.wr_en) &&
      $past(mem_if.wr_data) == {val_q[6:0], $past(flags_q[FLG_C])} &&
      flags_q[FLG_C] == val_q[7])
    else $error("rotate left through carry wrong");
  AST_ROT_R: assert property (
    INSTR_DONE && kind_q == K_ROT_R |-> $past(mem_if.wr_en) &&
      $past(mem_if.wr_data) == {val_q[0], val_q[7:1]} && flags_q[FLG_C] == val_q[0])
    else $error("rotate right wrong");
  AST_ROT_RC: assert property (
    INSTR_DONE && kind_q == K_ROT_RC |-> $past(mem_if.wr_en) &&
      $past(mem_if.wr_data) == {$past(flags_q[FLG_C]), val_q[7:1]} &&
      flags_q[FLG_C] == val_q[0])
    else $error("rotate right through carry wrong");
  AST_ROT_ZSDH: assert property (
    INSTR_DONE && rot_kind |-> flags_q[FLG_Z] == ($past(mem_if.wr_data) == 8'h00) &&
      flags_q[FLG_S] == $past(mem_if.wr_data[7]) &&
      flags_q[FLG_D] == $past(flags_q[FLG_D]) && flags_q[FLG_H] == $past(flags_q[FLG_H]))
    else $error("rotate zero sign or kept flags wrong");
  AST_ROT_V: assert property (
    INSTR_DONE && rot_kind |-> flags_q[FLG_V] == (val_q[7] ^ $past(mem_if.wr_data[7])))
    else $error("rotate overflow flag wrong");
  AST_ROT_TARGET: assert property (
    INSTR_DONE && rot_kind |-> $past(mem_if.wr_addr) ==
      (ind_q ? $past(mem_if.rd_data, 3) : opnd_q[REG_AW-1:0]))
    else $error("rotate wrote the wrong register");

  COV_RETURN: cover property (acc && INSTR_OPCODE == OP_RETURN ##13 INSTR_DONE);
  COV_ROT_IND: cover property (INSTR_DONE && rot_kind && ind_q);
  COV_WB_ACK: cover property (WB_ACK_O && !WB_WE_I);
  COV_IRQ: cover property (IRQ);

endmodule : rcr_exec_top

// [tb/rcr_dec_model.sv]
`timescale 1ns/1ns
// ************************************************************
// decoder side of the instruction port
// ************************************************************
module rcr_dec_model (
  // clock
  input wire logic clk,
  // handshake from the execution block
  input wire logic ready,
  input wire logic done,
  // instruction offer
  output logic valid,
  output logic [7:0] opcode,
  output logic [7:0] operand
);
  initial begin
    valid = 1'b0;
    opcode = 8'h00;
    operand = 8'h00;
  end

  // gap models a slow decoder; lat counts cycles from take to done, 40 means none
  task automatic issue(input int gap, input logic [7:0] op, input logic [7:0] opnd,
                       output int lat);
    repeat (gap) @(posedge clk);
    valid <= 1'b1;
    opcode <= op;
    operand <= opnd;
    do @(negedge clk); while (ready !== 1'b1);
    @(posedge clk);
    // released lines never echo the old byte
    valid <= 1'b0;
    opcode <= ~op;
    operand <= ~opnd;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (done !== 1'b1 && lat < 40);
    @(posedge clk);
  endtask : issue
endmodule : rcr_dec_model

// [tb/rotate_carry_return_exec_tb.sv]
`timescale 1ns/1ns
module rotate_carry_return_exec_tb import rcr_pkg::*; ;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk, rst, valid, ready, done, irq, cyc, stb, we, ack;
  logic [7:0] opcode, operand, adr, flags;
  logic [15:0] pc, sp;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int miscompares, check_count;

  rcr_exec_top #(.REG_AW(8)) rcr_exec_top_inst (
    .REF_CLK(clk), .RESET(rst), .INSTR_VALID(valid), .INSTR_OPCODE(opcode),
    .INSTR_OPERAND(operand), .INSTR_READY(ready), .INSTR_DONE(done), .PC_OUT(pc),
    .SP_OUT(sp), .FLAGS_OUT(flags), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .IRQ(irq));
  rcr_dec_model rcr_dec_model_inst (
    .clk(clk), .ready(ready), .done(done), .valid(valid), .opcode(opcode),
    .operand(operand));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one classic cycle; ack and read data taken at one rising edge, then cyc idles a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    wdat <= ~d;
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp, what);
  endtask : rd_chk

  task automatic set_reg(input logic [7:0] a, input logic [7:0] v);
    wr(ADR_REG_ADDR, {24'h0, a});
    wr(ADR_REG_DATA, {24'h0, v});
  endtask : set_reg

  task automatic run(input logic [7:0] op, input logic [7:0] opnd, input int exp_lat);
    int lat;
    rcr_dec_model_inst.issue(1, op, opnd, lat);
    chk(32'(lat), 32'(exp_lat), "cycles to done");
  endtask : run

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    chk({pc, sp}, 32'h0, "pc and sp after reset");
    chk({24'h0, flags}, 32'h0, "flags after reset");
    chk({30'h0, irq, ready}, 32'h1, "irq and ready after reset");
  endtask : t_reset

  task automatic t_carry_clear();
    wr(ADR_FLAGS, 32'hff);
    run(OP_CARRY_CLEAR, 8'h00, 5);
    chk({24'h0, flags}, 32'h7f, "flags after carry clear");
    rd_chk(ADR_FLAGS, 32'h7f, "flags read back");
  endtask : t_carry_clear

  task automatic t_return();
    wr(ADR_SP, 32'h00fc);
    wr(ADR_FLAGS, 32'h5d);
    set_reg(8'hfc, 8'h10);
    set_reg(8'hfd, 8'h1a);
    run(OP_RETURN, 8'h00, 13);
    chk({pc, sp}, 32'h101a00fe, "pc and sp after return");
    chk({24'h0, flags}, 32'h5d, "flags after return");
    rd_chk(ADR_PC, 32'h101a, "pc read back");
    rd_chk(ADR_SP, 32'h00fe, "sp read back");
  endtask : t_return

  // every rotate opcode, direct and indirect, on values covering zero, sign and carry edges
  task automatic t_rotates();
    logic [7:0] ops[8] = '{OP_ROT_L, OP_ROT_L_IND, OP_ROT_LC, OP_ROT_LC_IND,
                           OP_ROT_R, OP_ROT_R_IND, OP_ROT_RC, OP_ROT_RC_IND};
    logic [7:0] vals[4] = '{8'haa, 8'h31, 8'h00, 8'h80};
    logic [7:0] v, r, f, nf, tgt;
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 4; j++) begin
        v = vals[j];
        f = (j[0]) ? 8'h8e : 8'h0d;
        tgt = ops[i][0] ? 8'h02 : 8'h05;
        set_reg(8'h01, 8'h02);
        set_reg(tgt, v);
        wr(ADR_FLAGS, {24'h0, f});
        run(ops[i], ops[i][0] ? 8'h01 : 8'h05, 5);
        case (ops[i] & 8'hfe)
          OP_ROT_L: r = {v[6:0], v[7]};
          OP_ROT_LC: r = {v[6:0], f[FLG_C]};
          OP_ROT_R: r = {v[0], v[7:1]};
          default: r = {f[FLG_C], v[7:1]};
        endcase
        nf = f;
        nf[FLG_C] = ((ops[i] & 8'hfe) inside {OP_ROT_L, OP_ROT_LC}) ? v[7] : v[0];
        nf[FLG_Z] = (r == 8'h00);
        nf[FLG_S] = r[7];
        nf[FLG_V] = v[7] ^ r[7];
        chk({24'h0, flags}, {24'h0, nf}, "flags after rotate");
        wr(ADR_REG_ADDR, {24'h0, tgt});
        rd_chk(ADR_REG_DATA, {24'h0, r}, "rotate result");
        wr(ADR_REG_ADDR, 32'h01);
        rd_chk(ADR_REG_DATA, 32'h02, "pointer register");
      end
    end
  endtask : t_rotates

  task automatic t_irq();
    wr(ADR_IRQ_CLEAR, 32'h3);
    wr(ADR_IRQ_ENABLE, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq idle");
    run(OP_CARRY_CLEAR, 8'h00, 5);
    rd_chk(ADR_IRQ_STATUS, 32'h1, "status after done");
    chk({31'h0, irq}, 32'h1, "irq on done");
    wr(ADR_IRQ_CLEAR, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    run(8'hff, 8'h00, 40);
    rd_chk(ADR_IRQ_STATUS, 32'h2, "status after illegal");
    chk({31'h0, irq}, 32'h0, "masked illegal");
    wr(ADR_IRQ_ENABLE, 32'h3);
    rd_chk(ADR_IRQ_ENABLE, 32'h3, "enable read back");
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(ADR_IRQ_CLEAR, 32'h2);
    chk({31'h0, irq}, 32'h0, "irq cleared again");
    rd_chk(ADR_IRQ_CLEAR, 32'h0, "clear reads zero");
    rd_chk(8'h20, 32'h0, "unmapped read");
  endtask : t_irq

  task automatic final_report();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // ************************************************************
  // clock, reset, sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // whole run is under two thousand cycles; this only cuts a hang
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    miscompares = 0;
    check_count = 0;
    rst = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_carry_clear();
    t_return();
    t_rotates();
    t_irq();
    final_report();
  end
endmodule : rotate_carry_return_exec_tb
